// ==== core/cfg_sink.sv ====
// Configuration stream sink: link capture, crossing FIFO, byte unpacker and load sequencer
`timescale 1ns/100ps
`include "cfg_sink_defs.svh"

module cfg_word_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Write side, link clock
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  output logic [AW:0]           wr_free,
  // Read side, core clock
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  output logic [WIDTH-1:0]      rd_data,
  input  wire logic             rd_ready
);
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } side_t;

  side_t w_q, w_d, r_q, r_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      rptr_w;
  logic [AW:0]      wptr_r;
  logic             w_full;
  logic             r_empty;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    for (int i = AW; i >= 0; i--) begin
      b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

  always_comb begin
    rptr_w   = g2b(w_q.s2);
    w_full   = (w_q.bin[AW] != rptr_w[AW]) && (w_q.bin[AW-1:0] == rptr_w[AW-1:0]);
    wr_ready = !w_full;
    wr_free  = (AW+1)'(DEPTH) - (w_q.bin - rptr_w);
    w_d      = w_q;
    w_d.s1   = r_q.gray;
    w_d.s2   = w_q.s1;
    if (wr_valid && !w_full) begin
      w_d.bin  = w_q.bin + 1'b1;
      w_d.gray = w_d.bin ^ (w_d.bin >> 1);
    end
  end

  always_ff @(posedge wr_clk) begin
    if (!wr_rst_n) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
    if (wr_valid && !w_full) begin
      mem[w_q.bin[AW-1:0]] <= wr_data;
    end
  end

  always_comb begin
    wptr_r   = g2b(r_q.s2);
    r_empty  = (wptr_r == r_q.bin);
    rd_valid = !r_empty;
    rd_data  = mem[r_q.bin[AW-1:0]];
    r_d      = r_q;
    r_d.s1   = w_q.gray;
    r_d.s2   = r_q.s1;
    if (rd_ready && !r_empty) begin
      r_d.bin  = r_q.bin + 1'b1;
      r_d.gray = r_d.bin ^ (r_d.bin >> 1);
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule

module cfg_sink (
  // Core clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Stream link from the host
  input  wire logic        narrow_stream_clock,
  input  wire logic [31:0] stream_data,
  input  wire logic        stream_valid,
  output logic             stream_ready,
  // Control pins
  input  wire logic        restart_request_n,
  input  wire logic [2:0]  scheme_select,
  output logic             device_status_n,
  output logic             load_complete,
  output logic             user_mode,
  // Decompressor stall and total byte count expected
  input  wire logic        decomp_stall,
  input  wire logic [31:0] load_bytes,
  // Unpacked configuration bytes
  output logic [7:0]       cfg_byte,
  output logic             cfg_byte_valid
);
  typedef struct packed {
    logic                   lrst_s1;
    logic                   lrst_s2;
    logic [2:0]             width;
  } link_t;

  typedef struct packed {
    logic                   rq_s1;
    logic                   rq_s2;
    logic                   rq_s3;
    logic                   lrel_s1;
    logic                   lrel_s2;
    logic                   armed;
    logic                   run;
    cfg_sink_pkg::cfg_state_t st;
    logic [2:0]             sel;
    logic [31:0]            word;
    logic [2:0]             left;
    logic                   busy;
    logic [31:0]            count;
    logic [7:0]             init_cnt;
    logic                   ready;
    logic                   status;
    logic                   done;
    logic                   user;
    logic [7:0]             byte_q;
    logic                   byte_v;
  } core_t;

  link_t l_q, l_d;
  core_t c_q, c_d;
  cfg_sink_pkg::word_t in_w, out_w;
  logic       f_ready;
  logic [`FIFO_AW:0] f_free;
  logic       o_valid;
  logic       pop;
  logic       room_s1_q, room_s2_q, room_s3_q, f_ready_sync;

  // Link-domain reset follows the core run flag (load, init and user states), crossed through two flops
  always_comb begin
    l_d         = l_q;
    l_d.lrst_s1 = c_q.run;
    l_d.lrst_s2 = l_q.lrst_s1;
    l_d.width   = c_q.sel;
    in_w.data   = stream_data;
    in_w.width  = l_q.width;
  end

  always_ff @(posedge narrow_stream_clock) begin
    l_q <= l_d;
  end

  cfg_word_fifo #(.WIDTH($bits(cfg_sink_pkg::word_t)), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .wr_clk   (narrow_stream_clock),
    .wr_rst_n (l_q.lrst_s2),
    .wr_valid (stream_valid && l_q.lrst_s2),
    .wr_data  (in_w),
    .wr_ready (f_ready),
    .wr_free  (f_free),
    .rd_clk   (clk_sys),
    .rd_rst_n (c_q.run),
    .rd_valid (o_valid),
    .rd_data  (out_w),
    .rd_ready (pop)
  );

  always_comb begin
    c_d        = c_q;
    c_d.rq_s1  = restart_request_n;
    c_d.rq_s2  = c_q.rq_s1;
    c_d.rq_s3  = c_q.rq_s2;
    // link reset release seen only while the link clock runs
    c_d.lrel_s1 = l_q.lrst_s2;
    c_d.lrel_s2 = c_q.lrel_s1;
    c_d.byte_v = 1'b0;
    pop        = 1'b0;
    if (!c_q.rq_s3 && c_q.rq_s2 && c_q.armed) begin
      c_d.st     = cfg_sink_pkg::ST_LOAD;
      c_d.run    = 1'b1;
      c_d.status = 1'b1;
      c_d.done   = 1'b0;
      c_d.user   = 1'b0;
      c_d.count  = '0;
      c_d.busy   = 1'b0;
      c_d.sel    = scheme_select;
    end else if (!c_q.rq_s2) begin
      c_d.st     = cfg_sink_pkg::ST_RESET;
      c_d.armed  = 1'b1;
      c_d.run    = 1'b0;
      c_d.status = 1'b0;
      c_d.done   = 1'b0;
      c_d.user   = 1'b0;
    end else begin
      unique case (c_q.st)
        cfg_sink_pkg::ST_RESET: begin
          c_d.run = 1'b0;
        end
        cfg_sink_pkg::ST_LOAD: begin
          if (!c_q.busy && o_valid) begin
            pop      = 1'b1;
            c_d.word = out_w.data;
            c_d.busy = 1'b1;
            c_d.left = (out_w.width == `SEL_X32) ? 3'h3 : (out_w.width == `SEL_X16) ? 3'h1 : 3'h0;
          end else if (c_q.busy && !decomp_stall) begin
            c_d.byte_q = c_q.word[7:0];
            c_d.byte_v = 1'b1;
            c_d.word   = c_q.word >> 8;
            c_d.left   = c_q.left - 3'h1;
            c_d.busy   = (c_q.left != 3'h0);
            c_d.count  = c_q.count + 32'h1;
            if (c_q.count + 32'h1 == load_bytes) begin
              c_d.done     = 1'b1;
              c_d.busy     = 1'b0;
              c_d.st       = cfg_sink_pkg::ST_INIT;
              c_d.init_cnt = '0;
            end
          end
        end
        cfg_sink_pkg::ST_INIT: begin
          c_d.init_cnt = c_q.init_cnt + 8'h1;
          if (c_q.init_cnt == `INIT_CYCLES) begin
            c_d.st   = cfg_sink_pkg::ST_USER;
            c_d.user = 1'b1;
          end
        end
        cfg_sink_pkg::ST_USER: begin
          c_d.run = 1'b1;
        end
      endcase
    end
    // ready from core clock, room for the overrun allowance
    // Next state used so ready never outlives status on a restart clear
    c_d.ready = (c_d.st == cfg_sink_pkg::ST_LOAD) && !decomp_stall && c_q.lrel_s2 && f_ready_sync;
  end

  // Free-space flag crossed into the core domain through two flops
  always_ff @(posedge narrow_stream_clock) begin
    room_s1_q <= (f_free >= (`FIFO_AW+1)'(`FIFO_DEPTH - 1));
  end
  always_ff @(posedge clk_sys) begin
    room_s2_q <= room_s1_q;
    room_s3_q <= room_s2_q;
  end
  assign f_ready_sync = room_s3_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      c_q       <= '0;
      // Restart synchroniser idles high so no false edge follows reset
      c_q.rq_s1 <= 1'b1;
      c_q.rq_s2 <= 1'b1;
      c_q.rq_s3 <= 1'b1;
      c_q.st    <= cfg_sink_pkg::ST_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  always_comb begin
    stream_ready    = c_q.ready;
    device_status_n = c_q.status;
    load_complete   = c_q.done;
    user_mode       = c_q.user;
    cfg_byte        = c_q.byte_q;
    cfg_byte_valid  = c_q.byte_v;
  end
endmodule

// ==== core/cfg_sink_defs.svh ====
// Constants of the configuration stream sink
`ifndef CFG_SINK_DEFS_SVH
`define CFG_SINK_DEFS_SVH
`define SEL_X32          3'h0
`define SEL_X16          3'h5
`define SEL_X8           3'h6
`define OVERRUN_WORDS    6
`define FIFO_DEPTH       8
`define FIFO_AW          3
`define READY_MARGIN     4'h8
`define INIT_CYCLES      8'h40
`endif

// ==== core/cfg_sink_pkg.sv ====
// Types of the configuration stream sink
package cfg_sink_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  width;
  } word_t;

  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_LOAD  = 4'h2,
    ST_INIT  = 4'h4,
    ST_USER  = 4'h8
  } cfg_state_t;
endpackage

// ==== sim/cfg_host_model.sv ====
// Host model streaming numbered bytes into the sink
`timescale 1ns/100ps
module cfg_host_model (
  // Link
  input  wire logic        lclk,
  input  wire logic        rst_n,
  input  wire logic        stream_ready,
  output logic [31:0]      stream_data,
  output logic             stream_valid,
  // Control
  input  wire logic        go,
  input  wire logic [2:0]  bpw,
  input  wire logic [7:0]  nw
);
  logic       sync1_q;
  logic       sync2_q;
  logic [7:0] sent_q;
  always_ff @(posedge lclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= stream_ready;
      sync2_q <= sync1_q;
    end
  end
  // valid held low through reset and until ready is seen
  // lanes in file order, idle data inverted every clock
  always_ff @(posedge lclk) begin
    stream_valid <= 1'b0;
    stream_data  <= ~stream_data;
    if (!rst_n) begin
      stream_data <= 32'h0;
      sent_q      <= 8'h00;
    end else if (!go) begin
      sent_q <= 8'h00;
    end else if (sync2_q && sent_q < nw) begin
      stream_valid <= 1'b1;
      for (int j = 0; j < 4; j++)
        if (j < bpw) stream_data[8*j+:8] <= 8'(sent_q * bpw + j + 1);
      sent_q <= sent_q + 8'h01;
    end
  end
endmodule

// ==== sim/cfg_sink_bench.sv ====
// Bench for the configuration stream sink
`timescale 1ns/100ps
`include "cfg_sink_defs.svh"
module cfg_sink_bench;
  typedef struct packed {logic [2:0] sel; logic [2:0] bpw; logic [7:0] nw;} row_t;
  row_t        rows [3] = '{'{`SEL_X32, 3'h4, 8'h0A}, '{`SEL_X16, 3'h2, 8'h0C}, '{`SEL_X8, 3'h1, 8'h14}};
  logic        clk_sys = 0, lclk = 0, rst_n = 0, go = 0, sv, sr, rq_n = 1, st_n, done, user, stall = 0, bv;
  logic [2:0]  sel = 0, bpw = 1;
  logic [7:0]  nw = 0, cb;
  logic [31:0] sd, lb = 0;
  int          num_errors = 0, tests_run = 0, nb = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  // link clock runs through every load
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  cfg_host_model host (.lclk(lclk), .rst_n(rst_n), .stream_ready(sr), .stream_data(sd),
    .stream_valid(sv), .go(go), .bpw(bpw), .nw(nw));
  cfg_sink dut (.clk_sys(clk_sys), .rst_n(rst_n), .narrow_stream_clock(lclk), .stream_data(sd),
    .stream_valid(sv), .stream_ready(sr), .restart_request_n(rq_n), .scheme_select(sel),
    .device_status_n(st_n), .load_complete(done), .user_mode(user), .decomp_stall(stall),
    .load_bytes(lb), .cfg_byte(cb), .cfg_byte_valid(bv));
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task restart();
    rq_n = 0;
    go = 0;
    wait_clk(6);
    nb = 0;
    rq_n = 1;
    go = 1;
  endtask
  task wait_done();
    for (int k = 0; k < 3000 && done !== 1'b1; k++) wait_clk(1);
    check(done, 1);
  endtask
  // Bytes must come out in file order; sampled on the falling edge where settled
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
    if (bv === 1'b1) begin
      check(cb, 8'(nb + 1));
      nb++;
    end
  end
  initial begin
    wait_clk(10);
    check({sr, done, user, st_n}, 0);
    rst_n = 1;
    wait_clk(2);
    foreach (rows[i]) begin
      sel = rows[i].sel;
      bpw = rows[i].bpw;
      nw = rows[i].nw;
      lb = 32'(rows[i].bpw * rows[i].nw);
      restart();
      wait_clk(30);
      stall = 1;
      wait_clk(4);
      check(sr, 0);
      wait_clk(40);
      stall = 0;
      wait_done();
      wait_clk(70);
      check(nb, lb);
      check(user, 1);
    end
    restart();
    wait_clk(20);
    rq_n = 0;
    wait_clk(3);
    check({done, user}, 0);
    restart();
    wait_done();
    wait_clk(4);
    check(nb, lb);
    report_and_stop();
  end
endmodule

// ==== sim/cfg_sink_sva.sv ====
// Port assertions for the configuration sink
`timescale 1ns/100ps
module cfg_sink_sva (
  // Core clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Observed pins
  input wire logic stream_ready,
  input wire logic restart_request_n,
  input wire logic device_status_n,
  input wire logic load_complete,
  input wire logic user_mode,
  input wire logic decomp_stall,
  input wire logic cfg_byte_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ready_status: assert property (stream_ready |-> device_status_n)
    else $error("ready without status");
  a_stall_drops: assert property (decomp_stall [*2] |-> !stream_ready)
    else $error("ready during stall");
  a_restart_clear: assert property (!restart_request_n [*3] |=> !load_complete && !user_mode)
    else $error("restart did not clear");
  a_status_restart: assert property ($rose(restart_request_n) |-> ##[1:8] device_status_n)
    else $error("status late after restart");
  a_user_order: assert property ($rose(user_mode) |-> load_complete)
    else $error("user mode before load done");
  a_user_delay: assert property ($rose(load_complete) |-> !user_mode [*8])
    else $error("user mode too early");
  a_done_hold: assert property (load_complete && restart_request_n |=> load_complete)
    else $error("load complete dropped");
  a_byte_status: assert property (cfg_byte_valid |-> device_status_n)
    else $error("byte outside load");
  c_done: cover property ($rose(load_complete));
  c_user: cover property ($rose(user_mode));
  c_stall: cover property (decomp_stall ##1 !stream_ready);
endmodule
bind cfg_sink cfg_sink_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .stream_ready(stream_ready),
  .restart_request_n(restart_request_n), .device_status_n(device_status_n), .load_complete(load_complete),
  .user_mode(user_mode), .decomp_stall(decomp_stall), .cfg_byte_valid(cfg_byte_valid));
